// ===== rtl/motor_param_pkg.sv
// Purpose: Constants for the motor parameter status and control bank
// Assumes: Avalon word address equals the register index
// Notes:   Byte address of a register is four times its index
// Function
// R1: Resistance measurement state on status bit 31
// R2: Inductance measurement state on status bit 30
// R3: Back-EMF constant measurement state on bit 29
// R4: Mechanical measurement state on status bit 28
// R5: PWM code bits 27-24, low bits zero
// R6: Control bit 31 requests nonvolatile store
// R7: Control bit 30 requests default reload
// R8: Writing control bit 29 clears faults
// R9: Writing control bit 28 clears retry count
// R10: Nine-bit align angle at bits 19-11
// R11: Angle used when enabled, modulo 360
// R12: Host writes service bit each interval
// R13: Device clears service bit after host sets
`default_nettype none

package motor_param_pkg;

  // Register indices
  localparam logic [7:0]  STATUS_IDX = 8'he8;
  localparam logic [7:0]  CTRL_IDX   = 8'hea;

  // Reset values
  localparam logic [31:0] REG_RST    = 32'h0000_0000;
  localparam logic        WAIT_RST   = 1'b1;

  // Status field positions
  localparam int          RES_BIT    = 31;
  localparam int          IND_BIT    = 30;
  localparam int          KE_BIT     = 29;
  localparam int          MECH_BIT   = 28;
  localparam int          PWM_MSB    = 27;
  localparam int          PWM_LSB    = 24;
  localparam int          PWM_W      = 4;

  // Control field positions
  localparam int          STORE_BIT  = 31;
  localparam int          RELOAD_BIT = 30;
  localparam int          FCLR_BIT   = 29;
  localparam int          RCLR_BIT   = 28;
  localparam int          ANG_MSB    = 19;
  localparam int          ANG_LSB    = 11;
  localparam int          ANG_W      = 9;
  localparam int          TICKLE_BIT = 10;

  // Full turn in degrees
  localparam logic [8:0]  ANGLE_FULL = 9'h168;

  // Fold a programmed angle into one turn
  function automatic logic [8:0] wrap_angle(input logic [8:0] a);
    return (a >= ANGLE_FULL) ? 9'(a - ANGLE_FULL) : a;
  endfunction : wrap_angle

endpackage : motor_param_pkg

`default_nettype wire

// ===== rtl/align_angle_reg.sv
// Purpose: Registered forced-align angle, folded into one turn
// Assumes: Angle input is held in a register upstream
// Notes:   Output is zero while forced align is off
`default_nettype none

module align_angle_reg
  import motor_param_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  // Angle in
  input  wire logic             enable_i,
  input  wire logic [ANG_W-1:0] angle_i,
  // Angle out
  output var  logic [ANG_W-1:0] angle_o
);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      angle_o <= '0;
    end else if (enable_i) begin
      angle_o <= wrap_angle(angle_i); // R11
    end else begin
      angle_o <= '0; // R11
    end
  end

endmodule : align_angle_reg

`default_nettype wire

// ===== rtl/motor_param_regs.sv
// Purpose: Avalon-MM bank for parameter measurement status and control
// Assumes: Status inputs and nvm_done_i are synchronous to clk_i
// Notes:   Every access takes one wait state
`default_nettype none

module motor_param_regs
  import motor_param_pkg::*;
#(
  parameter int unsigned AW    = 8,
  parameter int unsigned WDT_W = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  // Avalon-MM slave
  input  wire logic [AW-1:0]    avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [31:0]      avs_writedata_i,
  input  wire logic [3:0]       avs_byteenable_i,
  output logic [31:0]           avs_readdata_o,
  output logic                  avs_waitrequest_o,
  // Measurement state
  input  wire logic             resistance_meas_state_i,
  input  wire logic             inductance_meas_state_i,
  input  wire logic             backemf_const_meas_state_i,
  input  wire logic             mechanical_meas_state_i,
  input  wire logic [PWM_W-1:0] backemf_meas_pwm_code_i,
  // Nonvolatile store
  output logic                  nvm_store_request_o,
  output logic                  nvm_reload_request_o,
  input  wire logic             nvm_done_i,
  // Fault handling
  output logic                  fault_clear_o,
  output logic                  retry_counter_clear_o,
  // Forced align
  input  wire logic             force_align_en_i,
  output logic [ANG_W-1:0]      align_angle_o,
  // Host watchdog
  input  wire logic             host_wdt_en_i,
  input  wire logic [WDT_W-1:0] host_watchdog_interval_i,
  output logic                  watchdog_service_o,
  output logic                  host_wdt_fault_o
);

  logic             wait_q;
  logic [31:0]      rdata_q;
  logic [31:0]      rmux;
  logic [7:0]       stat_q;
  logic             store_q;
  logic             reload_q;
  logic             fclr_q;
  logic             rclr_q;
  logic [ANG_W-1:0] angle_q;
  logic             tickle_q;
  logic             service_q;
  logic [WDT_W-1:0] wdt_cnt_q;
  logic             wdt_fault_q;
  logic             wdt_hit;
  logic             rd_req;
  logic             wr_acc;
  logic             wr_ctrl;
  logic             set_store;
  logic             set_reload;
  logic             set_fclr;
  logic             set_rclr;
  logic             set_angle;
  logic             set_tickle;

  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [7:0]    idx);
    return a == AW'(idx);
  endfunction : hit

  // Bus handshake: request seen with wait high, answered next cycle

  assign rd_req = avs_read_i && wait_q;
  assign wr_acc = avs_write_i && !wait_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_q <= WAIT_RST;
    end else if (wait_q) begin
      wait_q <= !(avs_read_i || avs_write_i);
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_comb begin
    rmux = REG_RST;
    if (hit(avs_address_i, STATUS_IDX)) begin
      rmux[RES_BIT:PWM_LSB] = stat_q; // R1 R2 R3 R4 R5
    end else if (hit(avs_address_i, CTRL_IDX)) begin
      rmux[STORE_BIT]  = store_q;
      rmux[RELOAD_BIT] = reload_q;
      rmux[TICKLE_BIT] = tickle_q;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= REG_RST;
    end else if (rd_req) begin
      rdata_q <= rmux;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o    = rdata_q;

  // Status capture

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat_q <= REG_RST[7:0];
    end else begin
      stat_q <= {resistance_meas_state_i,    // R1
                 inductance_meas_state_i,    // R2
                 backemf_const_meas_state_i, // R3
                 mechanical_meas_state_i,    // R4
                 backemf_meas_pwm_code_i};   // R5
    end
  end

  // Control write decode

  assign wr_ctrl    = wr_acc && hit(avs_address_i, CTRL_IDX);
  assign set_store  = wr_ctrl && avs_byteenable_i[3]
                      && avs_writedata_i[STORE_BIT];
  assign set_reload = wr_ctrl && avs_byteenable_i[3]
                      && avs_writedata_i[RELOAD_BIT];
  assign set_fclr   = wr_ctrl && avs_byteenable_i[3]
                      && avs_writedata_i[FCLR_BIT];
  assign set_rclr   = wr_ctrl && avs_byteenable_i[3]
                      && avs_writedata_i[RCLR_BIT];
  assign set_angle  = wr_ctrl && avs_byteenable_i[2]
                      && avs_byteenable_i[1];
  assign set_tickle = wr_ctrl && avs_byteenable_i[1]
                      && avs_writedata_i[TICKLE_BIT];

  // Store and reload requests stay up until the memory reports done

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      store_q <= REG_RST[STORE_BIT];
    end else if (set_store) begin
      store_q <= 1'b1; // R6
    end else if (nvm_done_i) begin
      store_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reload_q <= REG_RST[RELOAD_BIT];
    end else if (set_reload) begin
      reload_q <= 1'b1; // R7
    end else if (nvm_done_i) begin
      reload_q <= 1'b0;
    end
  end

  assign nvm_store_request_o  = store_q;
  assign nvm_reload_request_o = reload_q;

  // Clear strobes last one cycle and read back as zero

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fclr_q <= REG_RST[FCLR_BIT];
      rclr_q <= REG_RST[RCLR_BIT];
    end else begin
      fclr_q <= set_fclr; // R8
      rclr_q <= set_rclr; // R9
    end
  end

  assign fault_clear_o         = fclr_q;
  assign retry_counter_clear_o = rclr_q;

  // Align angle is write-only

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      angle_q <= REG_RST[ANG_MSB:ANG_LSB];
    end else if (set_angle) begin
      angle_q <= avs_writedata_i[ANG_MSB:ANG_LSB]; // R10
    end
  end

  align_angle_reg u_align (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .enable_i (force_align_en_i),
    .angle_i  (angle_q),
    .angle_o  (align_angle_o)
  );

  // Service bit lives one cycle, then the device drops it

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tickle_q  <= REG_RST[TICKLE_BIT];
      service_q <= 1'b0;
    end else begin
      tickle_q  <= set_tickle; // R13
      service_q <= set_tickle;
    end
  end

  assign watchdog_service_o = service_q;

  // Host watchdog: expires when no service arrives within the interval

  assign wdt_hit = host_wdt_en_i
                   && (host_watchdog_interval_i != '0)
                   && (wdt_cnt_q == host_watchdog_interval_i);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wdt_cnt_q <= '0;
    end else if (!host_wdt_en_i || service_q) begin
      wdt_cnt_q <= '0; // R12
    end else if (wdt_cnt_q != host_watchdog_interval_i) begin
      wdt_cnt_q <= wdt_cnt_q + WDT_W'(1);
    end
  end

  // A new expiry beats a clear in the same cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wdt_fault_q <= 1'b0;
    end else if (wdt_hit) begin
      wdt_fault_q <= 1'b1; // R12
    end else if (fclr_q) begin
      wdt_fault_q <= 1'b0; // R8
    end
  end

  assign host_wdt_fault_o = wdt_fault_q;

  // Checks

  default clocking cb @(posedge clk_i);
  endclocking

  default disable iff (!resetn_i);

  sequence s_status_rd;
    rd_req && hit(avs_address_i, STATUS_IDX);
  endsequence

  sequence s_ctrl_hi;
    wr_ctrl && avs_byteenable_i[3];
  endsequence

  sequence s_pulse(sig);
    sig ##1 !sig;
  endsequence

  chk_status_flags: assert property ( // R1 R2 R3 R4
    s_status_rd |=> avs_readdata_o[RES_BIT:MECH_BIT] ==
      $past({resistance_meas_state_i, inductance_meas_state_i,
             backemf_const_meas_state_i, mechanical_meas_state_i}, 2)
  ) else $error("status flags do not match measurement inputs");

  chk_status_pwm: assert property ( // R5
    s_status_rd |=> avs_readdata_o[PWM_MSB:PWM_LSB] ==
      $past(backemf_meas_pwm_code_i, 2) && avs_readdata_o[23:0] == '0
  ) else $error("pwm code or low status bits wrong");

  chk_store_hold: assert property ( // R6
    s_ctrl_hi ##0 avs_writedata_i[STORE_BIT] |=>
      nvm_store_request_o throughout (!nvm_done_i [*1])
  ) else $error("store request not raised or dropped early");

  chk_reload_set: assert property ( // R7
    s_ctrl_hi ##0 avs_writedata_i[RELOAD_BIT] |=>
      nvm_reload_request_o ##1 (nvm_reload_request_o || $past(nvm_done_i))
  ) else $error("reload request not raised or dropped early");

  chk_fault_pulse: assert property ( // R8
    s_ctrl_hi ##0 avs_writedata_i[FCLR_BIT] |=> s_pulse(fault_clear_o)
  ) else $error("fault clear is not a single-cycle pulse");

  chk_fault_drop: assert property ( // R8
    fault_clear_o && !wdt_hit |=> !host_wdt_fault_o
  ) else $error("watchdog fault survives a fault clear");

  chk_retry_pulse: assert property ( // R9
    s_ctrl_hi ##0 avs_writedata_i[RCLR_BIT] |=> s_pulse(retry_counter_clear_o)
  ) else $error("retry clear is not a single-cycle pulse");

  chk_angle_wrap: assert property ( // R10 R11
    force_align_en_i |=> align_angle_o == wrap_angle($past(angle_q))
      && align_angle_o < ANGLE_FULL
  ) else $error("align angle not folded into one turn");

  chk_angle_idle: assert property ( // R11
    !force_align_en_i |=> align_angle_o == '0
  ) else $error("align angle driven while forced align is off");

  chk_tickle_clear: assert property ( // R13
    set_tickle |=> watchdog_service_o && tickle_q ##1 !tickle_q
  ) else $error("service bit not cleared by the device");

  chk_wdt_expire: assert property ( // R12
    wdt_hit |=> host_wdt_fault_o
  ) else $error("watchdog expiry not flagged");

  chk_bus_answer: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=>
      !avs_waitrequest_o ##1 avs_waitrequest_o
  ) else $error("waitrequest did not drop for exactly one cycle");

  chk_read_hold: assert property (
    !rd_req |=> $stable(avs_readdata_o)
  ) else $error("read data changed without a read answer");

  chk_wait_idle: assert property (
    avs_waitrequest_o && !(avs_read_i || avs_write_i) |=> avs_waitrequest_o
  ) else $error("waitrequest dropped with no request");

  chk_store_keep: assert property ( // R6
    nvm_store_request_o && !nvm_done_i |=> nvm_store_request_o
  ) else $error("store request dropped before done");

  chk_reload_keep: assert property ( // R7
    nvm_reload_request_o && !nvm_done_i |=> nvm_reload_request_o
  ) else $error("reload request dropped before done");

  chk_tickle_gate: assert property ( // R13
    wr_ctrl && !avs_byteenable_i[1] |=> !watchdog_service_o
  ) else $error("service pulse without its byte enabled");

  chk_wdt_quiet: assert property ( // R12
    !host_wdt_fault_o && (!host_wdt_en_i || host_watchdog_interval_i == '0)
      |=> !host_wdt_fault_o
  ) else $error("watchdog fault raised while expiry is off");

endmodule : motor_param_regs

`default_nettype wire

// ===== tb/nvm_model.sv
// Purpose: Nonvolatile memory stand-in that answers store and reload requests
// Assumes: Requests are levels held until the done pulse
// Notes:   The bench sets the latency to answer promptly or slowly
`default_nettype none

module nvm_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // Requests
  input  wire logic       store_i,
  input  wire logic       reload_i,
  input  wire logic [7:0] lat_i,
  // Answer
  output var  logic       done_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] cnt_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q  <= 8'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (!(store_i || reload_i) || done_o) begin
        cnt_q <= 8'h00;
      end else if (cnt_q == lat_i) begin
        done_o <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule : nvm_model

`default_nettype wire

// ===== tb/motor_param_regs_bench.sv
// Purpose: Self-checking bench for the parameter status and control bank
// Assumes: One wait state per access, strobes one cycle after the write edge
// Notes:   Random status and angle values come from a fixed seed
`default_nettype none

module motor_param_regs_bench;
  import motor_param_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i, resetn_i, avs_read_i, avs_write_i, avs_waitrequest_o, nvm_done_i;
  logic [7:0] avs_address_i, lat;
  logic [31:0] avs_writedata_i, avs_readdata_o, q, seed;
  logic [3:0] avs_byteenable_i, st, pwm;
  logic st_req, rl_req, fclr, rclr, en, wen, svc, wfault;
  logic [8:0] ang;
  logic [15:0] ival;
  int n_mismatch, check_count, n;

  motor_param_regs u_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .resistance_meas_state_i(st[3]), .inductance_meas_state_i(st[2]),
    .backemf_const_meas_state_i(st[1]), .mechanical_meas_state_i(st[0]),
    .backemf_meas_pwm_code_i(pwm), .nvm_store_request_o(st_req),
    .nvm_reload_request_o(rl_req), .nvm_done_i(nvm_done_i),
    .fault_clear_o(fclr), .retry_counter_clear_o(rclr), .force_align_en_i(en),
    .align_angle_o(ang), .host_wdt_en_i(wen), .host_watchdog_interval_i(ival),
    .watchdog_service_o(svc), .host_wdt_fault_o(wfault));

  nvm_model u_nvm (.clk_i(clk_i), .resetn_i(resetn_i), .store_i(st_req),
    .reload_i(rl_req), .lat_i(lat), .done_o(nvm_done_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 50);
    q = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    if (k >= 50) begin
      n_mismatch++;
      end_of_test();
    end
  endtask : bus

  // Write a control bit, then look for its one-cycle strobe
  function automatic logic pick(input int b);
    return (b == FCLR_BIT) ? fclr : (b == RCLR_BIT) ? rclr : svc;
  endfunction : pick

  task automatic strobe(input int b);
    bus(1'b1, CTRL_IDX, 32'h1 << b);
    #1 chk(pick(b), 1'b1);
    @(posedge clk_i);
    #1 chk(pick(b), 1'b0);
  endtask : strobe

  function automatic logic [8:0] fold(input logic [8:0] a);
    return (a >= 9'd360) ? a - 9'd360 : a;
  endfunction : fold

  initial begin
    seed = 32'hb0ebea59;
    {avs_read_i, avs_write_i, en, wen} = '0;
    avs_address_i = 8'h00;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hf;
    {st, pwm} = 8'h00;
    ival = 16'h0014;
    lat = 8'h0a;
    resetn_i = 1'b0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    bus(1'b0, STATUS_IDX, 0);
    chk(q, 32'h0);
    bus(1'b0, CTRL_IDX, 0);
    chk(q, 32'h0);
    bus(1'b0, 8'he9, 0);
    chk(q, 32'h0);
    for (int i = 0; i < 10; i++) begin
      {st, pwm} <= (i < 2) ? {8{i[0]}} : 8'($random(seed));
      bus(1'b0, STATUS_IDX, 0);
      chk(q, {st, pwm, 24'h0});
    end
    $display("status test done");
    strobe(FCLR_BIT);
    strobe(RCLR_BIT);
    strobe(TICKLE_BIT);
    bus(1'b0, CTRL_IDX, 0);
    chk(q[TICKLE_BIT], 1'b0);
    avs_byteenable_i <= 4'h8;
    bus(1'b1, CTRL_IDX, 32'h1 << TICKLE_BIT);
    #1 chk(svc, 1'b0);
    @(posedge clk_i);
    avs_byteenable_i <= 4'hf;
    $display("strobe test done");
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, CTRL_IDX, 32'h1 << (STORE_BIT - i));
      #1 chk({st_req, rl_req}, 2'b10 >> i);
      bus(1'b0, CTRL_IDX, 0);
      chk(q[31:30], 2'b10 >> i);
      n = 0;
      while ((st_req | rl_req) !== 1'b0 && n < 40) begin
        @(posedge clk_i);
        n++;
      end
      chk(n < 40, 1'b1);
      if (n >= 40) end_of_test();
      lat <= 8'h00;
    end
    $display("nvm test done");
    en <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      logic [8:0] a;
      a = (i == 0) ? 9'd359 : (i == 1) ? 9'd360 : (i == 2) ? 9'd511 : 9'($random(seed));
      bus(1'b1, CTRL_IDX, 32'(a) << ANG_LSB);
      repeat (2) @(posedge clk_i);
      #1 chk(ang, fold(a));
    end
    @(posedge clk_i);
    en <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 chk(ang, 9'h0);
    $display("angle test done");
    @(posedge clk_i);
    wen <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, CTRL_IDX, 32'h1 << TICKLE_BIT);
      repeat (8) @(posedge clk_i);
    end
    chk(wfault, 1'b0);
    n = 0;
    while (wfault !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    chk(wfault, 1'b1);
    if (n >= 40) end_of_test();
    wen <= 1'b0;
    strobe(FCLR_BIT);
    chk(wfault, 1'b0);
    @(posedge clk_i);
    ival <= 16'h0000;
    wen  <= 1'b1;
    repeat (30) @(posedge clk_i);
    chk(wfault, 1'b0);
    wen <= 1'b0;
    $display("watchdog test done");
    end_of_test();
  end
endmodule : motor_param_regs_bench

`default_nettype wire
